// File: verilog/aeg_pkg.sv
// Purpose: constants and types for the active energy gain/offset accumulator
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: every offset and field is named here once, and every reset value but mode and mask
package aeg_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_GAIN = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_PNUM = 8'h08;
  localparam logic [7:0] ADDR_PDEN = 8'h0C;
  localparam logic [7:0] ADDR_EDIV = 8'h10;
  localparam logic [7:0] ADDR_HCC = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_ENERGY = 8'h24;
  localparam logic [7:0] ADDR_LINE_ENERGY = 8'h28;
  localparam logic [7:0] ADDR_PERIOD = 8'h2C;
  // field widths
  localparam int GAIN_W = 12;
  localparam int OFFSET_W = 16;
  localparam int PULSE_W = 12;
  localparam int EDIV_W = 8;
  localparam int HCC_W = 16;
  localparam int ENERGY_W = 24;
  localparam int PERIOD_W = 16;
  localparam int POWER_W = 22;
  // gain divisor exponent and fine accumulator fraction bits
  localparam int GAIN_SHIFT = 12;
  localparam int OFFSET_FRAC = 8;
  localparam int FINE_FRAC = 33;
  // field positions
  localparam int CTRL_LINE_MODE = 0;
  localparam int ST_LINE_DONE = 0;
  localparam int ST_ZERO_CROSS = 1;
  localparam int ST_ENERGY_WRAP = 2;
  localparam int ST_W = 3;
  // reset values
  localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 16'h0000;
  localparam logic [PULSE_W-1:0] PNUM_RST = 12'h03F;
  localparam logic [PULSE_W-1:0] PDEN_RST = 12'h03F;
  localparam logic [EDIV_W-1:0] EDIV_RST = 8'h00;
  localparam logic [HCC_W-1:0] HCC_RST = 16'hFFFF;
  // timing counts in input clock cycles
  localparam int UPDATE_CYCLES = 4;
  localparam int PERIOD_UNIT_CYCLES = 8;

  // calibration settings travel together
  typedef struct packed {
    logic signed [GAIN_W-1:0] gain;
    logic signed [OFFSET_W-1:0] offset;
    logic [PULSE_W-1:0] pulseNum;
    logic [PULSE_W-1:0] pulseDen;
    logic [EDIV_W-1:0] energyDiv;
    logic [HCC_W-1:0] halfCycleCount;
    logic lineMode;
  } aeg_cfg_t;
endpackage : aeg_pkg

// File: verilog/aeg_energy_cal.sv
// Purpose: active energy calibration datapath with line cycle accumulation
// Assumes: power samples come from logic on mclk; zero crossing from a pin
// Notes: registers over classic Wishbone, ack one cycle after the strobe
// Overview of operation
// - gain is signed, 0.0244 percent per step
// - energy scaled by one plus gain over 4096
// - energy registers update every fourth clock
// - signed offset added each update interval
// - offset low eight bits are fractional
// - offset step weighs 2^-33 of energy
// - line mode: count, interrupt low, present energy
// - half cycle count sets accumulation time
// - pulse ratio from numerator and denominator
// - divider affects registers, not pulse rate
// - line period measured in eight clock units
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module aeg_energy_cal (
  input wire logic mclk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_cyc_i, // wishbone cycle
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic signed [aeg_pkg::POWER_W-1:0] activePower, // active power sample
  input wire logic zeroCrossIn, // line zero crossing level, asynchronous
  output logic energyPulseOut, // one-cycle energy pulse
  output logic irqN // interrupt, active low level
);
  // configuration and state registers
  aeg_pkg::aeg_cfg_t cfg_reg;
  logic [aeg_pkg::ST_W-1:0] status_reg;
  logic [aeg_pkg::ST_W-1:0] mask_reg;
  logic [aeg_pkg::ENERGY_W-1:0] energy_reg;
  logic [aeg_pkg::ENERGY_W-1:0] lineAccum_reg;
  logic [aeg_pkg::ENERGY_W-1:0] lineEnergy_reg;
  logic [aeg_pkg::PERIOD_W-1:0] period_reg;
  logic [aeg_pkg::PERIOD_W-1:0] periodCnt_reg;
  logic [2:0] periodPre_reg;
  logic [aeg_pkg::HCC_W-1:0] hcCnt_reg;
  logic [aeg_pkg::FINE_FRAC-1:0] frac_reg;
  logic signed [aeg_pkg::EDIV_W+1:0] divCnt_reg;
  logic [15:0] pulseAcc_reg;
  logic [1:0] updPre_reg;
  logic zxMeta_reg;
  logic zxSync_reg;
  logic zxPrev_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic pulse_reg;

  // bus decode
  // a write lands at the edge where ack is sampled high, never earlier
  wire logic busReq = wb_cyc_i & wb_stb_i;
  wire logic wrStrobe = busReq & wb_we_i & ack_reg;
  wire logic wrGain = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_GAIN);
  wire logic wrOffset = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_OFFSET);
  wire logic wrPnum = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_PNUM);
  wire logic wrPden = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_PDEN);
  wire logic wrEdiv = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_EDIV);
  wire logic wrHcc = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_HCC);
  wire logic wrCtrl = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_CTRL);
  wire logic wrStatus = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_STATUS);
  wire logic wrMask = wrStrobe & (wb_adr_i == aeg_pkg::ADDR_MASK);

  // byte-lane merge so partial writes keep untouched bytes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  wire logic [31:0] mGain = laneMerge({20'h00000, cfg_reg.gain}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mOffset = laneMerge({16'h0000, cfg_reg.offset}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mPnum = laneMerge({20'h00000, cfg_reg.pulseNum}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mPden = laneMerge({20'h00000, cfg_reg.pulseDen}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mEdiv = laneMerge({24'h000000, cfg_reg.energyDiv}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mHcc = laneMerge({16'h0000, cfg_reg.halfCycleCount}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mCtrl = laneMerge({31'h00000000, cfg_reg.lineMode}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mMask = laneMerge({29'h00000000, mask_reg}, wb_dat_i, wb_sel_i);
  wire logic [31:0] mClr = laneMerge(32'h00000000, wb_dat_i, wb_sel_i);

  // read mux; unmapped addresses read zero but are still acknowledged
  logic [31:0] rdMux;
  always_comb begin
    unique case (wb_adr_i)
      aeg_pkg::ADDR_GAIN: rdMux = {20'h00000, cfg_reg.gain};
      aeg_pkg::ADDR_OFFSET: rdMux = {16'h0000, cfg_reg.offset};
      aeg_pkg::ADDR_PNUM: rdMux = {20'h00000, cfg_reg.pulseNum};
      aeg_pkg::ADDR_PDEN: rdMux = {20'h00000, cfg_reg.pulseDen};
      aeg_pkg::ADDR_EDIV: rdMux = {24'h000000, cfg_reg.energyDiv};
      aeg_pkg::ADDR_HCC: rdMux = {16'h0000, cfg_reg.halfCycleCount};
      aeg_pkg::ADDR_CTRL: rdMux = {31'h00000000, cfg_reg.lineMode};
      aeg_pkg::ADDR_STATUS: rdMux = {29'h00000000, status_reg};
      aeg_pkg::ADDR_MASK: rdMux = {29'h00000000, mask_reg};
      aeg_pkg::ADDR_ENERGY: rdMux = {8'h00, energy_reg};
      aeg_pkg::ADDR_LINE_ENERGY: rdMux = {8'h00, lineEnergy_reg};
      aeg_pkg::ADDR_PERIOD: rdMux = {16'h0000, period_reg};
      default: rdMux = 32'h00000000;
    endcase
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= busReq & ~ack_reg;
      if (busReq & ~ack_reg) begin
        rdat_reg <= rdMux;
      end
    end
  end
  assign wb_ack_o = ack_reg & busReq;
  assign wb_dat_o = rdat_reg;

  wire logic updEn = (updPre_reg == 2'(aeg_pkg::UPDATE_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      updPre_reg <= 2'h0;
    end else begin
      updPre_reg <= updPre_reg + 2'h1;
    end
  end

  // zero crossing synchroniser; half cycle on either edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      zxMeta_reg <= 1'b0;
      zxSync_reg <= 1'b0;
      zxPrev_reg <= 1'b0;
    end else begin
      zxMeta_reg <= zeroCrossIn;
      zxSync_reg <= zxMeta_reg;
      zxPrev_reg <= zxSync_reg;
    end
  end
  wire logic zxRise = zxSync_reg & ~zxPrev_reg;
  wire logic halfCycle = zxSync_reg ^ zxPrev_reg;

  // signed gain, scale by 1 + gain/2^12
  // product keeps full width; the shift drops only gain fraction bits
  wire logic signed [aeg_pkg::POWER_W+aeg_pkg::GAIN_W-1:0] gainProd = activePower * cfg_reg.gain;
  wire logic signed [aeg_pkg::POWER_W:0] gainedPower =
    (aeg_pkg::POWER_W+1)'(activePower) +
    (aeg_pkg::POWER_W+1)'(gainProd >>> aeg_pkg::GAIN_SHIFT);
  // offset has eight fraction bits below the internal lsb
  // fine fraction spans 2^-33 of the visible energy lsb
  wire logic signed [35:0] offsetTerm = 36'(cfg_reg.offset);
  wire logic signed [35:0] powerTerm = 36'(gainedPower) <<< aeg_pkg::OFFSET_FRAC;
  wire logic signed [35:0] fineSum = $signed({3'b000, frac_reg}) + powerTerm + offsetTerm;
  // input width keeps the carry within plus or minus one lsb
  wire logic signed [2:0] carry = fineSum[35:33];
  wire logic carryUp = updEn & (carry == 3'sh1);
  wire logic carryDn = updEn & (carry == -3'sh1);

  // divider prescales only the register path
  wire logic signed [aeg_pkg::EDIV_W+1:0] divLimit = (aeg_pkg::EDIV_W+2)'(cfg_reg.energyDiv) +
    (aeg_pkg::EDIV_W+2)'(1);
  wire logic signed [aeg_pkg::EDIV_W+1:0] divStep = carryUp ? divCnt_reg + 10'sh001 :
    carryDn ? divCnt_reg - 10'sh001 : divCnt_reg;
  // compare by magnitude so a count left from a larger divider
  // steps at once instead of running past a smaller new limit
  wire logic stepUp = (divStep >= divLimit);
  wire logic stepDn = (divStep <= -divLimit);
  wire logic [aeg_pkg::ENERGY_W-1:0] energyNext = stepUp ? energy_reg + 24'h000001 :
    stepDn ? energy_reg - 24'h000001 : energy_reg;
  wire logic energyWrap = (stepUp & (energy_reg == 24'h7FFFFF)) |
    (stepDn & (energy_reg == 24'h800000));

  // fine fraction and divided energy registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frac_reg <= '0;
      divCnt_reg <= '0;
      energy_reg <= '0;
    end else begin
      if (updEn) begin
        frac_reg <= fineSum[aeg_pkg::FINE_FRAC-1:0];
      end
      divCnt_reg <= (stepUp | stepDn) ? '0 : divStep;
      energy_reg <= energyNext;
    end
  end

  // pulse ratio: (num+1)/(den+1) per undivided lsb
  wire logic [15:0] numInc = 16'(cfg_reg.pulseNum) + 16'h0001;
  wire logic [15:0] denLim = 16'(cfg_reg.pulseDen) + 16'h0001;
  wire logic [15:0] pulseSum = carryUp ? pulseAcc_reg + numInc : pulseAcc_reg;
  wire logic pulseFire = (pulseSum >= denLim);
  // backlog drains one pulse per clock, so a ratio settles only while it stays below the clocks between carries
  // negative carries never pulse; reverse energy is not metered out
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pulseAcc_reg <= 16'h0000;
      pulse_reg <= 1'b0;
    end else begin
      pulseAcc_reg <= pulseFire ? pulseSum - denLim : pulseSum;
      pulse_reg <= pulseFire;
    end
  end
  assign energyPulseOut = pulse_reg;

  // line period in units of eight clocks, saturating
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      periodPre_reg <= 3'h0;
      periodCnt_reg <= '0;
      period_reg <= '0;
    end else begin
      // prescaler restarts at one: the rise clock is the first of its unit,
      // so a period of eight times n clocks reads back as n
      periodPre_reg <= zxRise ? 3'h1 : periodPre_reg + 3'h1;
      if (zxRise) begin
        period_reg <= periodCnt_reg;
        periodCnt_reg <= '0;
      end else if ((periodPre_reg == 3'(aeg_pkg::PERIOD_UNIT_CYCLES - 1)) &&
                   (periodCnt_reg != 16'hFFFF)) begin
        periodCnt_reg <= periodCnt_reg + 16'h0001;
      end
    end
  end

  // count half cycles up to the programmed count
  // a count or mode write restarts the period at once, so the next one starts mid half cycle
  wire logic restartLine = wrHcc | wrCtrl;
  wire logic lineDone = cfg_reg.lineMode & halfCycle &
    ((hcCnt_reg + 16'h0001) >= cfg_reg.halfCycleCount);
  wire logic [aeg_pkg::ENERGY_W-1:0] lineStep = stepUp ? 24'h000001 :
    stepDn ? 24'hFFFFFF : 24'h000000;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hcCnt_reg <= '0;
      lineAccum_reg <= '0;
      lineEnergy_reg <= '0;
    end else if (restartLine | ~cfg_reg.lineMode) begin
      hcCnt_reg <= '0;
      lineAccum_reg <= '0;
    end else if (lineDone) begin
      hcCnt_reg <= '0;
      lineEnergy_reg <= lineAccum_reg + lineStep;
      lineAccum_reg <= '0;
    end else begin
      hcCnt_reg <= halfCycle ? hcCnt_reg + 16'h0001 : hcCnt_reg;
      lineAccum_reg <= lineAccum_reg + lineStep;
    end
  end

  // configuration writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_reg.gain <= aeg_pkg::GAIN_RST;
      cfg_reg.offset <= aeg_pkg::OFFSET_RST;
      cfg_reg.pulseNum <= aeg_pkg::PNUM_RST;
      cfg_reg.pulseDen <= aeg_pkg::PDEN_RST;
      cfg_reg.energyDiv <= aeg_pkg::EDIV_RST;
      cfg_reg.halfCycleCount <= aeg_pkg::HCC_RST;
      cfg_reg.lineMode <= 1'b0;
      mask_reg <= '0;
    end else begin
      if (wrGain) cfg_reg.gain <= mGain[aeg_pkg::GAIN_W-1:0];
      if (wrOffset) cfg_reg.offset <= mOffset[aeg_pkg::OFFSET_W-1:0];
      if (wrPnum) cfg_reg.pulseNum <= mPnum[aeg_pkg::PULSE_W-1:0];
      if (wrPden) cfg_reg.pulseDen <= mPden[aeg_pkg::PULSE_W-1:0];
      if (wrEdiv) cfg_reg.energyDiv <= mEdiv[aeg_pkg::EDIV_W-1:0];
      if (wrHcc) cfg_reg.halfCycleCount <= mHcc[aeg_pkg::HCC_W-1:0];
      if (wrCtrl) cfg_reg.lineMode <= mCtrl[aeg_pkg::CTRL_LINE_MODE];
      if (wrMask) mask_reg <= mMask[aeg_pkg::ST_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  // zero crossing and wrap flags suit polling; mask them for a quiet pin
  wire logic [aeg_pkg::ST_W-1:0] stSet = {energyWrap, halfCycle, lineDone & ~restartLine};
  wire logic [aeg_pkg::ST_W-1:0] stClr = wrStatus ? mClr[aeg_pkg::ST_W-1:0] : '0;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~stClr) | stSet;
    end
  end

  // interrupt pin goes low while an unmasked event is pending
  assign irqN = ~|(status_reg & mask_reg);
endmodule : aeg_energy_cal

// File: testbench/aeg_energy_cal_asserts.sv
// Purpose: port-level checks for the energy calibration block
// Assumes: one clock, synchronous active-low reset, full-word writes
// Notes: shadows follow register writes that carry all four lanes
`timescale 1ns/1ps
module aeg_energy_cal_asserts (
  input wire logic mclk, // clock
  input wire logic resetn, // reset, active low
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_we_i, // write
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic wb_stb_i, // strobe
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_ack_o, // acknowledge
  input wire logic energyPulseOut, // energy pulse
  input wire logic irqN // interrupt, active low
);
  logic [11:0] gainSh;
  logic [15:0] hccSh;
  logic [2:0] maskSh;
  // acked transfers
  wire wrAck = wb_ack_o && wb_we_i && (wb_sel_i == 4'hF);
  wire rdAck = wb_ack_o && !wb_we_i;
  // shadows of writable fields, reset to their documented values
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gainSh <= aeg_pkg::GAIN_RST;
      hccSh <= aeg_pkg::HCC_RST;
      maskSh <= 3'h0;
    end else if (wrAck && wb_adr_i == aeg_pkg::ADDR_GAIN) begin
      gainSh <= wb_dat_i[11:0];
    end else if (wrAck && wb_adr_i == aeg_pkg::ADDR_HCC) begin
      hccSh <= wb_dat_i[15:0];
    end else if (wrAck && wb_adr_i == aeg_pkg::ADDR_MASK) begin
      maskSh <= wb_dat_i[2:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  unmapped_zero_a: assert property (rdAck && wb_adr_i > aeg_pkg::ADDR_PERIOD |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  gain_readback_a: assert property (rdAck && wb_adr_i == aeg_pkg::ADDR_GAIN
    |-> wb_dat_o == {20'h0, gainSh}) else $error("gain readback differs");
  hcc_readback_a: assert property (rdAck && wb_adr_i == aeg_pkg::ADDR_HCC
    |-> wb_dat_o == {16'h0, hccSh}) else $error("half cycle count readback differs");
  energy_width_a: assert property (rdAck && wb_adr_i == aeg_pkg::ADDR_ENERGY
    |-> wb_dat_o[31:24] == 8'h0) else $error("energy above 24 bits");
  mask_quiet_a: assert property (maskSh == 3'h0 |-> irqN)
    else $error("interrupt low while all masked");
  irq_sticky_a: assert property (!irqN && !(wb_ack_o && wb_we_i) |=> !irqN)
    else $error("interrupt dropped without a write");
  irq_reset_a: assert property (disable iff (1'b0) !resetn |=> irqN)
    else $error("interrupt low after reset");
  // main scenarios reached
  line_done_c: cover property ($fell(irqN));
  pulse_seen_c: cover property (energyPulseOut);
  unmapped_c: cover property (rdAck && wb_adr_i > aeg_pkg::ADDR_PERIOD);
endmodule : aeg_energy_cal_asserts

// File: testbench/aeg_host.sv
// Purpose: host firmware model on the register bus
// Assumes: classic Wishbone, one request at a time
// Notes: the bench calls its tasks by hierarchical name
`timescale 1ns/1ps
module aeg_host (
  input wire logic mclk, // clock
  output logic [7:0] adr, // byte address
  output logic [31:0] datW, // write data
  output logic we, // write enable
  output logic cyc, // cycle and strobe
  input wire logic ack, // acknowledge
  input wire logic [31:0] datR, // read data
  input wire logic irqN // interrupt, active low
);
  // idle bus at time zero
  initial begin
    adr = 8'hFF;
    datW = 32'h0;
    we = 1'b0;
    cyc = 1'b0;
  end
  // one cycle; ack and read data taken at the rising edge, then released there
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w,
                     output logic [31:0] q);
    @(posedge mclk);
    adr <= a;
    datW <= d;
    we <= w;
    cyc <= 1'b1;
    // no assumed latency: only the bench timeout ends a hung wait
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    adr <= ~a; // released lines show no stale value
    datW <= ~d;
  endtask : bus
  // bounded wait for the interrupt line
  task automatic waitIrq();
    for (int n = 0; n < 4000; n++) begin
      @(negedge mclk);
      if (!irqN) break;
    end
  endtask : waitIrq
  task automatic calSetup(input logic [11:0] den, input logic [15:0] hc);
    logic [31:0] q;
    bus(aeg_pkg::ADDR_PDEN, {20'h0, den}, 1'b1, q);
    bus(aeg_pkg::ADDR_PNUM, 32'h0, 1'b1, q);
    bus(aeg_pkg::ADDR_CTRL, 32'h1, 1'b1, q);
    bus(aeg_pkg::ADDR_MASK, 32'h1, 1'b1, q);
    bus(aeg_pkg::ADDR_HCC, {16'h0, hc}, 1'b1, q);
    bus(aeg_pkg::ADDR_STATUS, 32'h7, 1'b1, q);
  endtask : calSetup
  // first result dropped, next read straight after the event
  task automatic lineResult(output logic [31:0] q);
    waitIrq();
    bus(aeg_pkg::ADDR_STATUS, 32'h7, 1'b1, q);
    waitIrq();
    bus(aeg_pkg::ADDR_LINE_ENERGY, 32'h0, 1'b0, q);
  endtask : lineResult
endmodule : aeg_host

// File: testbench/testbench.sv
// Purpose: self-checking bench for the energy calibration block
// Assumes: 125 MHz clock, line half cycle of 256 clocks
// Notes: energy rows compare two reads 1024 clocks apart
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  typedef struct {
    logic [11:0] g; // gain
    logic [15:0] o; // offset
    logic [21:0] p; // power
    logic [7:0] v; // divider
    logic [11:0] f; // pulse denominator
    logic [23:0] d; // energy step
    int n; // pulses
  } aeg_row_t;
  aeg_row_t rows[8] = '{
    '{12'h000, 16'h0000, 22'h100000, 8'h00, 12'h07F, 24'h000008, 4}, // two per pulse
    '{12'h000, 16'h0000, 22'h100000, 8'h00, 12'h03F, 24'h000008, 8}, // plain rate
    '{12'h800, 16'h0000, 22'h100000, 8'h00, 12'h03F, 24'h000004, 4}, // gain halves
    '{12'h400, 16'h0000, 22'h100000, 8'h00, 12'h03F, 24'h00000A, 10}, // gain up
    '{12'h000, 16'h0100, 22'h0FFFFF, 8'h00, 12'h03F, 24'h000008, 8}, // fraction
    '{12'h000, 16'h0000, 22'h100000, 8'h01, 12'h03F, 24'h000004, 8}, // divider
    '{12'h000, 16'hFF00, 22'h100001, 8'h00, 12'h03F, 24'h000008, 8}, // negative offset
    '{12'h000, 16'h0000, 22'h300000, 8'h00, 12'h03F, 24'hFFFFF8, 0} // negative power
  };
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic signed [aeg_pkg::POWER_W-1:0] power = '0;
  logic zc = 1'b0;
  logic [7:0] adr;
  logic [31:0] datW, datR, q, e0, e1;
  logic we, cyc, ack, energyPulseOut, irqN;
  int n_mismatch = 0;
  int cmp_count = 0;
  int pulses = 0;
  int cycles = 0;
  int k;
  aeg_host aeg_host_inst (.mclk(mclk), .adr(adr), .datW(datW), .we(we), .cyc(cyc),
    .ack(ack), .datR(datR), .irqN(irqN));
  aeg_energy_cal aeg_energy_cal_inst (.mclk(mclk), .resetn(resetn), .wb_adr_i(adr),
    .wb_dat_i(datW), .wb_dat_o(datR), .wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(cyc),
    .wb_cyc_i(cyc), .wb_ack_o(ack), .activePower(power), .zeroCrossIn(zc),
    .energyPulseOut(energyPulseOut), .irqN(irqN));
  always #4 mclk = ~mclk;
  // line source: a half cycle every 256 clocks, free running
  always begin
    repeat (256) @(posedge mclk);
    zc <= ~zc;
  end
  // pulse tally sampled mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    if (energyPulseOut === 1'b1) pulses++;
  end
  // hang guard, about two and a half times the expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    aeg_host_inst.bus(aeg_pkg::ADDR_HCC, 32'h0, 1'b0, q);
    `CHK("hcc reset", 32'h0000FFFF, q)
    aeg_host_inst.bus(aeg_pkg::ADDR_PDEN, 32'h0, 1'b0, q);
    `CHK("den reset", 32'h0000003F, q)
    aeg_host_inst.bus(aeg_pkg::ADDR_EDIV, 32'h0, 1'b0, q);
    `CHK("div reset", 32'h0, q)
    aeg_host_inst.bus(8'h3C, 32'h0, 1'b0, q);
    $display("test reset done");
    foreach (rows[i]) begin
      power <= rows[i].p;
      aeg_host_inst.bus(aeg_pkg::ADDR_GAIN, {20'h0, rows[i].g}, 1'b1, q);
      aeg_host_inst.bus(aeg_pkg::ADDR_GAIN, 32'h0, 1'b0, q);
      `CHK("gain readback", 32'(rows[i].g), q)
      aeg_host_inst.bus(aeg_pkg::ADDR_OFFSET, {16'h0, rows[i].o}, 1'b1, q);
      aeg_host_inst.bus(aeg_pkg::ADDR_EDIV, {24'h0, rows[i].v}, 1'b1, q);
      aeg_host_inst.bus(aeg_pkg::ADDR_PDEN, {20'h0, rows[i].f}, 1'b1, q);
      repeat (200) @(posedge mclk);
      aeg_host_inst.bus(aeg_pkg::ADDR_ENERGY, 32'h0, 1'b0, e0);
      k = pulses;
      repeat (1021) @(posedge mclk);
      aeg_host_inst.bus(aeg_pkg::ADDR_ENERGY, 32'h0, 1'b0, e1);
      `CHK("energy step", rows[i].d, e1[23:0] - e0[23:0])
      `CHK("pulse count", rows[i].n, pulses - k)
      $display("test row %0d done", i);
    end
    power <= 22'h100000;
    aeg_host_inst.calSetup(12'h03F, 16'h0003);
    aeg_host_inst.lineResult(q);
    `CHK("line energy", 32'h6, q)
    aeg_host_inst.bus(aeg_pkg::ADDR_STATUS, 32'h0, 1'b0, q);
    `CHK("status", 32'h3, q)
    aeg_host_inst.bus(aeg_pkg::ADDR_PERIOD, 32'h0, 1'b0, q);
    `CHK("period", 32'h40, q)
    aeg_host_inst.bus(aeg_pkg::ADDR_MASK, 32'h0, 1'b1, q);
    @(negedge mclk);
    `CHK("irq masked", 1'b1, irqN)
    aeg_host_inst.bus(aeg_pkg::ADDR_MASK, 32'h1, 1'b1, q);
    @(negedge mclk);
    `CHK("irq unmasked", 1'b0, irqN)
    aeg_host_inst.bus(aeg_pkg::ADDR_STATUS, 32'h1, 1'b1, q);
    @(negedge mclk);
    `CHK("irq cleared", 1'b1, irqN)
    $display("test line mode done");
    summarize();
  end
endmodule : testbench
bind aeg_energy_cal aeg_energy_cal_asserts aeg_energy_cal_asserts_inst (.mclk(mclk),
  .resetn(resetn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
  .wb_ack_o(wb_ack_o), .energyPulseOut(energyPulseOut), .irqN(irqN));
